//--- upf_channel.sv
// Overview of operation
// - open-drain active-low irq pin pulls low while any masked condition is active
// - software reads an irq status register naming the active conditions
// - receive line carries least significant bit first; characters assembled that way
// - external receive clock: serial input sampled on its rising edge
// - internal receive clock: sampled on rising edge of the internal 1x clock
// - transmitter sends each character least significant bit first
// - transmit pin held high when idle or in local loopback; after disable a character in flight finishes
// - external transmit clock: new bit shifted out on its falling edge
// - internal transmit clock: output changes on falling internal 1x edge only
// - multi-purpose output shows one of eight software-selected functions
// - after reset the multi-purpose output shows request-to-send
// - command codes 8h and 9h assert and negate request-to-send
// - auto mode negates request-to-send after last character or on full receiver
// - request-to-send normally tells the remote end the receiver has room
// - input pin level always readable in bit 0 of two registers
// - mode two bit 4 makes the input an active-low clear-to-send
// - the input has a change-of-state detector
// - irq sources: tx ready, rx ready/full, break change, timer, input change
// - status bits ignore the mask; mask only gates the irq pin
`timescale 1ns/1ps
module upf_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic rx_ext_clk,
  input wire logic tx_ext_clk,
  input wire logic multi_in0_pin,
  output logic multi_out_pin,
  input wire logic timer_out,
  input wire logic timer_terminal,
  output logic irq_request_n,
  output logic irq_request_n_oe
);
  // software-visible state
  logic [7:0] mode_reg_one;
  logic [7:0] mode_reg_two;
  upf_pkg::upf_mpo_e output_pin_config;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_status_reg;
  logic [1:0] clk_sel;
  logic [15:0] baud_div;
  logic rx_en;
  logic tx_en;
  logic rts_active;
  logic overrun;
  logic brk_active;
  logic brk_change;
  logic in_delta;
  logic in_level;
  logic [7:0] thr_data;
  logic thr_full;

  // receive buffer: four fifo words plus the shift-register hold slot
  upf_pkg::upf_rx_word_s fifo_mem [0:3];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] fifo_count;
  upf_pkg::upf_rx_word_s hold_word;
  logic hold_valid;
  upf_pkg::upf_rx_word_s push_word;
  upf_pkg::upf_rx_word_s next_hold_word;
  logic next_hold_valid;
  logic do_push;
  logic ovr_event;

  // pin synchronisers and clocks
  logic [1:0] rxd_sync;
  logic [1:0] rxc_sync;
  logic [1:0] txc_sync;
  logic [1:0] mpi_sync;
  logic rxc_last;
  logic txc_last;
  logic mpi_last;
  logic [15:0] div_cnt;
  logic [3:0] phase16;
  logic tick16;
  logic clk16;
  logic int_1x;
  logic rx_tick;
  logic tx_tick;
  logic rx_clk_1x;
  logic tx_clk_1x;

  // bus and datapath glue
  logic apb_loaded;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic cmd_wr;
  logic [3:0] cmd_code;
  logic pop;
  logic [31:0] rd_value;
  logic rd_hit;
  logic [7:0] status_byte;
  logic loop;
  logic rx_bit;
  logic tx_go;
  logic tx_serial;
  logic tx_busy;
  logic tx_taken;
  logic tx_done;
  logic tx_holding_empty;
  logic rx_avail_or_full;
  logic fifo_full;
  upf_pkg::upf_rx_word_s rx_word;
  logic rx_valid;

  // true when the address equals the given offset, in any phase of the transfer
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // apb: read data is registered in the setup cycle, so zero wait states
  assign pready = ce && apb_loaded && penable;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign pslverr = pready && !rd_hit;
  assign cmd_wr = wr_acc && hit(paddr, upf_pkg::OFS_COMMAND);
  assign cmd_code = pwdata[7:4];
  assign pop = rd_acc && hit(paddr, upf_pkg::OFS_DATA) && (fifo_count != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_loaded <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (acc) begin
        apb_loaded <= 1'b0;
      end else if (psel && !apb_loaded) begin
        apb_loaded <= 1'b1;
        prdata <= rd_value;
      end
    end
  end

  // read decode; unmapped addresses read zero and answer with pslverr
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(paddr, upf_pkg::OFS_MODE_ONE)) begin
      rd_value[7:0] = mode_reg_one;
    end else if (hit(paddr, upf_pkg::OFS_MODE_TWO)) begin
      rd_value[7:0] = mode_reg_two;
    end else if (hit(paddr, upf_pkg::OFS_COMMAND)) begin
      rd_value = 32'h0000_0000;
    end else if (hit(paddr, upf_pkg::OFS_DATA)) begin
      rd_value[7:0] = fifo_mem[rd_ptr].data;
    end else if (hit(paddr, upf_pkg::OFS_STATUS)) begin
      rd_value[7:0] = status_byte;
    end else if (hit(paddr, upf_pkg::OFS_PIN_CFG)) begin
      rd_value[2:0] = output_pin_config;
    end else if (hit(paddr, upf_pkg::OFS_IN_CHANGE)) begin
      rd_value[upf_pkg::IN_LEVEL_BIT] = in_level;
      rd_value[upf_pkg::IN_DELTA_BIT] = in_delta;
    end else if (hit(paddr, upf_pkg::OFS_IN_PORT)) begin
      rd_value[upf_pkg::IN_LEVEL_BIT] = in_level;
    end else if (hit(paddr, upf_pkg::OFS_IRQ_STATUS)) begin
      rd_value[7:0] = irq_status_reg;
    end else if (hit(paddr, upf_pkg::OFS_IRQ_MASK)) begin
      rd_value[7:0] = irq_mask_reg;
    end else if (hit(paddr, upf_pkg::OFS_CLK_SEL)) begin
      rd_value[1:0] = clk_sel;
    end else if (hit(paddr, upf_pkg::OFS_BAUD_DIV)) begin
      rd_value[15:0] = baud_div;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg_one <= 8'h00;
      mode_reg_two <= 8'h00;
      output_pin_config <= upf_pkg::MPO_RTS;
      irq_mask_reg <= 8'h00;
      clk_sel <= 2'h0;
      baud_div <= upf_pkg::BAUD_DIV_RESET;
    end else if (ce && wr_acc) begin
      if (hit(paddr, upf_pkg::OFS_MODE_ONE)) begin
        mode_reg_one <= pwdata[7:0];
      end else if (hit(paddr, upf_pkg::OFS_MODE_TWO)) begin
        mode_reg_two <= pwdata[7:0];
      end else if (hit(paddr, upf_pkg::OFS_PIN_CFG)) begin
        output_pin_config <= upf_pkg::upf_mpo_e'(pwdata[2:0]);
      end else if (hit(paddr, upf_pkg::OFS_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[7:0];
      end else if (hit(paddr, upf_pkg::OFS_CLK_SEL)) begin
        clk_sel <= pwdata[1:0];
      end else if (hit(paddr, upf_pkg::OFS_BAUD_DIV)) begin
        baud_div <= pwdata[15:0];
      end
    end
  end

  // enables: disable wins over enable in the same write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
    end else if (ce && cmd_wr) begin
      if (pwdata[upf_pkg::CMD_RX_DIS_BIT] || cmd_code == upf_pkg::CMD_RESET_RX) begin
        rx_en <= 1'b0;
      end else if (pwdata[upf_pkg::CMD_RX_EN_BIT]) begin
        rx_en <= 1'b1;
      end
      if (pwdata[upf_pkg::CMD_TX_DIS_BIT] || cmd_code == upf_pkg::CMD_RESET_TX) begin
        tx_en <= 1'b0;
      end else if (pwdata[upf_pkg::CMD_TX_EN_BIT]) begin
        tx_en <= 1'b1;
      end
    end
  end

  // transmit holding register; a write in the take cycle keeps it full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_data <= 8'h00;
      thr_full <= 1'b0;
    end else if (ce) begin
      if (cmd_wr && cmd_code == upf_pkg::CMD_RESET_TX) begin
        thr_full <= 1'b0;
      end else if (wr_acc && hit(paddr, upf_pkg::OFS_DATA)) begin
        thr_data <= pwdata[7:0];
        thr_full <= 1'b1;
      end else if (tx_taken) begin
        thr_full <= 1'b0;
      end
    end
  end

  // serial, both clock and input pins pass two flops (not the timer pins); stage 0 feeds only stage 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync <= 2'h3;
      rxc_sync <= 2'h0;
      txc_sync <= 2'h0;
      mpi_sync <= 2'h3;
      rxc_last <= 1'b0;
      txc_last <= 1'b0;
    end else if (ce) begin
      rxd_sync <= {rxd_sync[0], serial_in};
      rxc_sync <= {rxc_sync[0], rx_ext_clk};
      txc_sync <= {txc_sync[0], tx_ext_clk};
      mpi_sync <= {mpi_sync[0], multi_in0_pin};
      rxc_last <= rxc_sync[1];
      txc_last <= txc_sync[1];
    end
  end

  // baud divider: 16x tick every baud_div cycles, 1x from a phase count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      phase16 <= 4'h0;
    end else if (ce) begin
      if (tick16) begin
        div_cnt <= baud_div - 16'h0001;
        phase16 <= phase16 + 4'h1;
      end else begin
        div_cnt <= div_cnt - 16'h0001;
      end
    end
  end

  assign tick16 = (div_cnt == 16'h0000);
  assign clk16 = (div_cnt < {1'b0, baud_div[15:1]});
  assign int_1x = phase16[3];
  assign rx_clk_1x = clk_sel[upf_pkg::CLK_RX_EXT_BIT] ? rxc_sync[1] : int_1x;
  assign tx_clk_1x = clk_sel[upf_pkg::CLK_TX_EXT_BIT] ? txc_sync[1] : int_1x;

  // rising 1x edge samples, falling 1x edge shifts
  always_comb begin
    if (clk_sel[upf_pkg::CLK_RX_EXT_BIT]) begin
      rx_tick = rxc_sync[1] && !rxc_last;
    end else begin
      rx_tick = tick16 && (phase16 == upf_pkg::PHASE_RISE);
    end
    if (clk_sel[upf_pkg::CLK_TX_EXT_BIT]) begin
      tx_tick = !txc_sync[1] && txc_last;
    end else begin
      tx_tick = tick16 && (phase16 == upf_pkg::PHASE_FALL);
    end
  end

  // local loopback turns the transmitter back into the receiver
  assign loop = (mode_reg_two[7:6] == upf_pkg::CHAN_LOCAL_LOOP);
  assign rx_bit = loop ? tx_serial : rxd_sync[1];
  assign tx_go = thr_full && tx_en && !(mode_reg_two[upf_pkg::MODE2_CTS_BIT] && in_level);

  upf_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .shift_tick(tx_tick),
    .go(tx_go),
    .data(thr_data),
    .serial(tx_serial),
    .busy(tx_busy),
    .taken(tx_taken),
    .done(tx_done)
  );

  upf_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .enable(rx_en),
    .sample_tick(rx_tick),
    .rx_bit(rx_bit),
    .word(rx_word),
    .valid(rx_valid)
  );

  // pin forced to mark when idle or looped; a character in flight finishes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out <= 1'b1;
    end else if (ce) begin
      serial_out <= (loop || !tx_busy) ? 1'b1 : tx_serial;
    end
  end

  // receive path: hold slot catches a word while the fifo is full
  always_comb begin
    do_push = 1'b0;
    push_word = rx_word;
    next_hold_valid = hold_valid;
    next_hold_word = hold_word;
    ovr_event = 1'b0;
    if (hold_valid) begin
      if (pop) begin
        do_push = 1'b1;
        push_word = hold_word;
        next_hold_valid = rx_valid;
        next_hold_word = rx_word;
      end else if (rx_valid) begin
        ovr_event = 1'b1; // newest word lost, older ones kept
      end
    end else if (rx_valid) begin
      if (!fifo_full || pop) begin
        do_push = 1'b1;
      end else begin
        next_hold_valid = 1'b1;
        next_hold_word = rx_word;
      end
    end
  end

  assign fifo_full = (fifo_count == upf_pkg::FIFO_DEPTH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fifo_count <= 3'h0;
      hold_valid <= 1'b0;
      hold_word <= '0;
      for (int i = 0; i < 4; i++) begin
        fifo_mem[i] <= '0;
      end
    end else if (ce) begin
      if (cmd_wr && cmd_code == upf_pkg::CMD_RESET_RX) begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        fifo_count <= 3'h0;
        hold_valid <= 1'b0;
      end else begin
        if (do_push) begin
          fifo_mem[wr_ptr] <= push_word;
          wr_ptr <= wr_ptr + 2'h1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 2'h1;
        end
        fifo_count <= fifo_count + {2'h0, do_push} - {2'h0, pop};
        hold_valid <= next_hold_valid;
        hold_word <= next_hold_word;
      end
    end
  end

  // sticky error flags; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
      brk_active <= 1'b0;
      brk_change <= 1'b0;
    end else if (ce) begin
      if (ovr_event) begin
        overrun <= 1'b1;
      end else if (cmd_wr && cmd_code == upf_pkg::CMD_RESET_ERR) begin
        overrun <= 1'b0;
      end
      if (!brk_active && rx_valid && rx_word.brk) begin
        brk_active <= 1'b1;
        brk_change <= 1'b1;
      end else if (brk_active && rx_bit) begin
        brk_active <= 1'b0;
        brk_change <= 1'b1;
      end else if (cmd_wr && cmd_code == upf_pkg::CMD_RESET_BRK) begin
        brk_change <= 1'b0;
      end
    end
  end

  // request-to-send: commands, then auto negation takes priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_active <= 1'b0;
    end else if (ce) begin
      if (mode_reg_one[upf_pkg::MODE1_AUTO_RTS_BIT] && ((tx_done && !thr_full) || hold_valid)) begin
        rts_active <= 1'b0;
      end else if (cmd_wr && cmd_code == upf_pkg::CMD_RTS_ON) begin
        rts_active <= 1'b1;
      end else if (cmd_wr && cmd_code == upf_pkg::CMD_RTS_OFF) begin
        rts_active <= 1'b0;
      end
    end
  end

  // change detector: level accepted only after two equal synced samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mpi_last <= 1'b1;
      in_level <= 1'b1;
      in_delta <= 1'b0;
    end else if (ce) begin
      mpi_last <= mpi_sync[1];
      if (mpi_sync[1] == mpi_last && mpi_last != in_level) begin
        in_level <= mpi_last;
        in_delta <= 1'b1;
      end else if (rd_acc && hit(paddr, upf_pkg::OFS_IN_CHANGE)) begin
        in_delta <= 1'b0;
      end
    end
  end

  // status views
  assign tx_holding_empty = tx_en && !thr_full;
  assign rx_avail_or_full = mode_reg_one[upf_pkg::MODE1_FULL_SEL_BIT] ? fifo_full : (fifo_count != 3'h0);
  assign status_byte = {fifo_mem[rd_ptr].brk, fifo_mem[rd_ptr].ferr, 1'b0, overrun,
                        !thr_full && !tx_busy, tx_holding_empty, fifo_full, fifo_count != 3'h0};

  // unmasked condition levels
  always_comb begin
    irq_status_reg = 8'h00;
    irq_status_reg[upf_pkg::IRQ_TX_BIT] = tx_holding_empty;
    irq_status_reg[upf_pkg::IRQ_RX_BIT] = rx_avail_or_full;
    irq_status_reg[upf_pkg::IRQ_BRK_BIT] = brk_change;
    irq_status_reg[upf_pkg::IRQ_TIMER_BIT] = timer_terminal;
    irq_status_reg[upf_pkg::IRQ_INPUT_BIT] = in_delta;
  end

  // open drain: only ever pulls low, the pull-up makes the high
  assign irq_request_n = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_n_oe <= 1'b0;
    end else if (ce) begin
      irq_request_n_oe <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // multi-purpose output selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_out_pin <= 1'b1;
    end else if (ce) begin
      case (output_pin_config)
        upf_pkg::MPO_RTS: multi_out_pin <= !rts_active;
        upf_pkg::MPO_TIMER: multi_out_pin <= timer_out;
        upf_pkg::MPO_TX1X: multi_out_pin <= tx_clk_1x;
        upf_pkg::MPO_TX16X: multi_out_pin <= clk16;
        upf_pkg::MPO_RX1X: multi_out_pin <= rx_clk_1x;
        upf_pkg::MPO_RX16X: multi_out_pin <= clk16;
        upf_pkg::MPO_TX_HOLDING_EMPTY: multi_out_pin <= tx_holding_empty;
        default: multi_out_pin <= rx_avail_or_full;
      endcase
    end
  end
endmodule

//--- upf_pkg.sv
package upf_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] OFS_MODE_ONE = 8'h00;
  localparam logic [7:0] OFS_MODE_TWO = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PIN_CFG = 8'h14;
  localparam logic [7:0] OFS_IN_CHANGE = 8'h18;
  localparam logic [7:0] OFS_IN_PORT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_CLK_SEL = 8'h28;
  localparam logic [7:0] OFS_BAUD_DIV = 8'h2c;

  // field positions
  localparam int MODE1_AUTO_RTS_BIT = 7;
  localparam int MODE1_FULL_SEL_BIT = 6;
  localparam int MODE2_CTS_BIT = 4;
  localparam int CMD_RX_EN_BIT = 0;
  localparam int CMD_RX_DIS_BIT = 1;
  localparam int CMD_TX_EN_BIT = 2;
  localparam int CMD_TX_DIS_BIT = 3;
  localparam int CLK_TX_EXT_BIT = 0;
  localparam int CLK_RX_EXT_BIT = 1;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_BRK_BIT = 2;
  localparam int IRQ_TIMER_BIT = 3;
  localparam int IRQ_INPUT_BIT = 4;
  localparam int IN_LEVEL_BIT = 0;
  localparam int IN_DELTA_BIT = 4;

  // channel mode field in mode_reg_two[7:6]
  localparam logic [1:0] CHAN_LOCAL_LOOP = 2'h2;

  // command codes in command_reg[7:4]
  localparam logic [3:0] CMD_RESET_RX = 4'h2;
  localparam logic [3:0] CMD_RESET_TX = 4'h3;
  localparam logic [3:0] CMD_RESET_ERR = 4'h4;
  localparam logic [3:0] CMD_RESET_BRK = 4'h5;
  localparam logic [3:0] CMD_RTS_ON = 4'h8;
  localparam logic [3:0] CMD_RTS_OFF = 4'h9;

  // reset values and counts
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0004;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] CHAR_LAST_BIT = 3'h7;
  localparam logic [3:0] PHASE_RISE = 4'h7;
  localparam logic [3:0] PHASE_FALL = 4'hf;

  typedef enum logic [2:0] {
    MPO_RTS = 3'h0, MPO_TIMER = 3'h1, MPO_TX1X = 3'h2, MPO_TX16X = 3'h3,
    MPO_RX1X = 3'h4, MPO_RX16X = 3'h5, MPO_TX_HOLDING_EMPTY = 3'h6, MPO_RXRDY = 3'h7
  } upf_mpo_e;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_DATA = 4'b0010, TX_STOP = 4'b0100, TX_END = 4'b1000
  } upf_tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001, RX_DATA = 3'b010, RX_STOP = 3'b100
  } upf_rx_state_e;

  typedef struct packed {
    logic brk;
    logic ferr;
    logic [7:0] data;
  } upf_rx_word_s;
endpackage

//--- upf_tx.sv
`timescale 1ns/1ps
module upf_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic shift_tick,
  input wire logic go,
  input wire logic [7:0] data,
  output logic serial,
  output logic busy,
  output logic taken,
  output logic done
);
  upf_pkg::upf_tx_state_e state;
  logic [7:0] shreg;
  logic [2:0] cnt;

  // bits only move on the shift tick, i.e. the falling 1x edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= upf_pkg::TX_IDLE;
      serial <= 1'b1;
      shreg <= 8'h00;
      cnt <= 3'h0;
      taken <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      taken <= 1'b0;
      done <= 1'b0;
      if (shift_tick) begin
        case (state)
          upf_pkg::TX_IDLE, upf_pkg::TX_END: begin
            // back to back characters skip the idle slot
            done <= (state == upf_pkg::TX_END) && !go;
            if (go) begin
              serial <= 1'b0;
              shreg <= data;
              cnt <= 3'h0;
              taken <= 1'b1;
              state <= upf_pkg::TX_DATA;
            end else begin
              state <= upf_pkg::TX_IDLE;
            end
          end
          upf_pkg::TX_DATA: begin
            serial <= shreg[0];
            shreg <= {1'b0, shreg[7:1]};
            cnt <= cnt + 3'h1;
            if (cnt == upf_pkg::CHAR_LAST_BIT) begin
              state <= upf_pkg::TX_STOP;
            end
          end
          upf_pkg::TX_STOP: begin
            serial <= 1'b1;
            state <= upf_pkg::TX_END;
          end
          default: state <= upf_pkg::TX_IDLE;
        endcase
      end
    end
  end

  assign busy = (state != upf_pkg::TX_IDLE);
endmodule

//--- upf_rx.sv
`timescale 1ns/1ps
module upf_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic sample_tick,
  input wire logic rx_bit,
  output upf_pkg::upf_rx_word_s word,
  output logic valid
);
  upf_pkg::upf_rx_state_e state;
  logic [7:0] shreg;
  logic [2:0] cnt;

  // one sample per rising 1x edge; no mid-bit search, the clock sets the phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= upf_pkg::RX_IDLE;
      shreg <= 8'h00;
      cnt <= 3'h0;
      word <= '0;
      valid <= 1'b0;
    end else if (ce) begin
      valid <= 1'b0;
      if (sample_tick) begin
        case (state)
          upf_pkg::RX_IDLE: begin
            if (enable && !rx_bit) begin
              cnt <= 3'h0;
              state <= upf_pkg::RX_DATA;
            end
          end
          upf_pkg::RX_DATA: begin
            shreg <= {rx_bit, shreg[7:1]};
            cnt <= cnt + 3'h1;
            if (cnt == upf_pkg::CHAR_LAST_BIT) begin
              state <= upf_pkg::RX_STOP;
            end
          end
          upf_pkg::RX_STOP: begin
            word.data <= shreg;
            word.ferr <= !rx_bit;
            word.brk <= !rx_bit && (shreg == 8'h00);
            valid <= 1'b1;
            state <= upf_pkg::RX_IDLE;
          end
          default: state <= upf_pkg::RX_IDLE;
        endcase
      end
    end
  end
endmodule

//--- upf_chk.sv
`timescale 1ns/1ps
module upf_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic serial_out,
  input wire logic multi_out_pin,
  input wire logic timer_out,
  input wire logic timer_terminal,
  input wire logic irq_request_n,
  input wire logic irq_request_n_oe
);
  logic wr;
  logic [4:0] msk;
  logic [2:0] cfg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow mask and pin function from completed writes
  assign wr = psel & penable & pready & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk <= 5'h0;
      cfg <= 3'h0;
    end else if (wr) begin
      if (paddr == 8'h24) msk <= pwdata[4:0];
      if (paddr == 8'h14) cfg <= pwdata[2:0];
    end
  end
  sequence s_rts(c);
    wr && paddr == 8'h08 && pwdata[7:4] == c && cfg == 3'h0;
  endsequence
  property p_od; irq_request_n == 1'b0; endproperty
  a_od: assert property (p_od) else $error("irq value");
  property p_rst; !$past(presetn) |-> serial_out && multi_out_pin; endproperty
  a_rst: assert property (p_rst) else $error("reset pins");
  property p_msk; msk == 5'h0 && $past(msk) == 5'h0 |-> !irq_request_n_oe; endproperty
  a_msk: assert property (p_msk) else $error("masked irq");
  property p_src; msk[3] && timer_terminal |-> ##[1:2] irq_request_n_oe; endproperty
  a_src: assert property (p_src) else $error("no irq");
  property p_on; s_rts(4'h8) |-> ##[1:3] !multi_out_pin; endproperty
  a_on: assert property (p_on) else $error("rts on");
  property p_off; s_rts(4'h9) |-> ##[1:3] multi_out_pin; endproperty
  a_off: assert property (p_off) else $error("rts off");
  property p_bit; $changed(serial_out) |=> $stable(serial_out) [*8]; endproperty
  a_bit: assert property (p_bit) else $error("short bit");
  property p_tmr; $past(cfg) == 3'h1 && cfg == 3'h1 |-> multi_out_pin == $past(timer_out); endproperty
  a_tmr: assert property (p_tmr) else $error("timer route");
endmodule
bind upf_channel upf_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .pwrite, .paddr, .pwdata,
  .serial_out, .multi_out_pin, .timer_out, .timer_terminal, .irq_request_n, .irq_request_n_oe);

//--- upf_far.sv
`timescale 1ns/1ps
module upf_far (
  input wire logic pclk,
  input wire logic line_in,
  input wire logic clk1x,
  output logic line_out
);
  logic [7:0] got;
  int n_got = 0;
  initial line_out = 1'b1;
  // mid-bit sampling, 64 pclk a bit at the reset divisor
  always begin
    @(negedge line_in);
    repeat (32) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (64) @(posedge pclk);
      got[i] = line_in;
    end
    repeat (64) @(posedge pclk);
    n_got++;
  end
  // change data on falling rx 1x edges so rises land mid-bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk1x); // the switch of pin function may give a false fall
    for (int i = 0; i < 10; i++) begin
      @(negedge clk1x);
      @(posedge pclk);
      line_out <= f[i];
    end
  endtask
endmodule

//--- upf_channel_tb_top.sv
`timescale 1ns/1ps
module upf_channel_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, serial_in, serial_out, multi_out_pin, irq_request_n, irq_request_n_oe;
  logic multi_in0_pin = 1'b0, timer_out = 1'b0, timer_terminal = 1'b0, rx_ext_clk = 1'b0, tx_ext_clk = 1'b0;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #50 pclk = ~pclk;
  upf_channel dut_u (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .serial_in, .serial_out, .rx_ext_clk, .tx_ext_clk, .multi_in0_pin, .multi_out_pin,
    .timer_out, .timer_terminal, .irq_request_n, .irq_request_n_oe);
  upf_far far_u (.pclk, .line_in(serial_out), .clk1x(multi_out_pin), .line_out(serial_in));
  // request held until pready seen at a rising edge; data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (t == 20) err_count++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wt(input int n);
    for (int t = 0; t < 2000 && far_u.n_got != n; t++) @(posedge pclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // counter source and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    timer_out <= cyc[2];
    if (cyc == 8000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h14, 32'h0);
    rdc(8'h30, 32'h0);
    chk({31'h0, se}, 32'h1);
    xfer(1'b1, 8'h08, 32'h85);
    repeat (3) @(posedge pclk);
    chk({31'h0, multi_out_pin}, 32'h0);
    xfer(1'b1, 8'h08, 32'h90);
    repeat (3) @(posedge pclk);
    chk({31'h0, multi_out_pin}, 32'h1);
    xfer(1'b1, 8'h0c, 32'ha5);
    wt(1);
    chk({24'h0, far_u.got}, 32'ha5);
    xfer(1'b1, 8'h04, 32'h10);
    multi_in0_pin <= 1'b1;
    xfer(1'b1, 8'h0c, 32'h3c);
    repeat (200) @(posedge pclk);
    chk({31'h0, serial_out}, 32'h1);
    multi_in0_pin <= 1'b0;
    wt(2);
    chk({24'h0, far_u.got}, 32'h3c);
    rdc(8'h18, 32'h10);
    rdc(8'h1c, 32'h0);
    xfer(1'b1, 8'h14, 32'h4);
    far_u.send(8'h96);
    repeat (100) @(posedge pclk);
    rdc(8'h0c, 32'h96);
    xfer(1'b1, 8'h04, 32'h80);
    xfer(1'b1, 8'h0c, 32'h5a);
    repeat (300) @(posedge pclk);
    chk({31'h0, serial_out}, 32'h1);
    repeat (500) @(posedge pclk);
    rdc(8'h0c, 32'h5a);
    xfer(1'b1, 8'h14, 32'h1);
    xfer(1'b1, 8'h24, 32'h8);
    timer_terminal <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_request_n_oe}, 32'h1);
    rdc(8'h20, 32'h9);
    xfer(1'b1, 8'h24, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_request_n_oe}, 32'h0);
    wrap_up();
  end
endmodule
